// File: design/rsc_ctrl.sv
// Purpose: Reset source controller for a small 8-bit microcontroller.
// Assumes: rst_i is the power-on reset; pins are asynchronous.
// Notes: Holds the registers whose reset state depends on the source.
`timescale 1ns/1ps
module rsc_ctrl #(
    parameter int LSR_CYC = rsc_pkg::LOW_SUPPLY_MIN_CYC,
    parameter int SST_CYC = rsc_pkg::STARTUP_DELAY_CYC,
    parameter int WDT_W = rsc_pkg::WDT_BITS
) (
    input wire logic mclk_i,                   // System clock.
    input wire logic rst_i,                    // Power-on reset, high.
    input wire logic external_reset_pin_n_i,   // Reset pin, active low.
    input wire logic low_supply_det_i,         // Supply monitor, high=low.
    input wire logic low_supply_enable_i,      // Option: supply reset on.
    input wire logic wdt_enable_i,             // Option: watchdog on.
    input wire logic clr_wdt_i,                // Core clears watchdog.
    input wire logic enter_halt_i,             // Core enters power-down.
    input wire logic wake_i,                   // Interrupt wake from halt.
    input wire rsc_pkg::rsc_bus_t bus_i,       // Register port request.
    output logic [7:0] rdata_o,                // Read data, next cycle.
    output logic cpu_run_o,                    // Execution allowed.
    output logic prescaler_clr_o,              // Timer prescaler clear.
    output logic timer_run_o,                  // Timer run bit.
    output logic [7:0] interrupt_control_o,    // Interrupt control.
    output logic [7:0] port_a_data_o,          // Port A data latch.
    output logic [7:0] port_a_direction_o,     // Port A direction.
    output logic [7:0] program_counter_low_o,  // Program counter low.
    output logic [7:0] stack_ptr_o,            // Stack pointer.
    output logic watchdog_expired_flag_o,      // Time-out flag.
    output logic powered_down_flag_o,          // Power-down flag.
    output rsc_pkg::rsc_cause_t cause_o        // Last reset source.
);
    import rsc_pkg::*;

    localparam int LSR_W = $clog2(LSR_CYC + 2);
    localparam int SST_W = $clog2(SST_CYC + 1);
    localparam logic [LSR_W-1:0] LSR_FIRE = LSR_W'(LSR_CYC + 1);
    localparam logic [SST_W-1:0] SST_LAST = SST_W'(SST_CYC - 1);

    // Refuse settings the counters cannot serve.
    if (LSR_CYC < 1 || SST_CYC < 1 || WDT_W < 2) begin : g_bad
        $error("rsc_ctrl: counts must be positive and WDT_W at least 2");
    end

    logic pin_n_s;
    logic low_s;

    // Every pin source passes two flops first.
    rsc_sync #(
        .W(2),
        .RST_VAL(2'b10)
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i({external_reset_pin_n_i, low_supply_det_i}),
        .q_o({pin_n_s, low_s})
    );

    rsc_state_t state_r, state_nxt;
    logic [SST_W-1:0] sst_r, sst_nxt;
    logic [LSR_W-1:0] lsr_r, lsr_nxt;
    logic [WDT_W-1:0] wdt_r, wdt_nxt;
    logic halted_r, halted_nxt;
    logic to_r, to_nxt;
    logic pdf_r, pdf_nxt;
    logic [3:0] alu_r, alu_nxt;
    logic [7:0] interrupt_control_reg_r, interrupt_control_reg_nxt;
    logic [7:0] timer_control_reg_r, timer_control_reg_nxt;
    logic [7:0] tmr_r, tmr_nxt;
    logic [7:0] pa_r, pa_nxt;
    logic [7:0] padir_r, padir_nxt;
    logic [7:0] pwm_r, pwm_nxt;
    logic [7:0] convh_r, convh_nxt;
    logic [7:0] convc_r, convc_nxt;
    logic [7:0] pcl_r, pcl_nxt;
    logic [7:0] sp_r, sp_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic psc_r, psc_nxt;
    rsc_cause_t cause_r, cause_nxt;

    logic lvr_active;
    logic pin_low;
    logic hold_rst;
    logic wd_evt;
    logic wd_run_evt;
    logic wd_halt_evt;
    logic full_rst;

    // The filter only fires once low supply outlasts the minimum.
    assign lvr_active = low_supply_enable_i && (lsr_r == LSR_FIRE);
    assign pin_low = !pin_n_s;
    // Pin and supply resets hold the core for as long as they last.
    assign hold_rst = pin_low || lvr_active;
    assign wd_evt = (state_r == RSC_RUN) && wdt_enable_i && (&wdt_r);
    // Pin and supply resets take precedence over the watchdog.
    assign wd_run_evt = wd_evt && !halted_r && !hold_rst;
    assign wd_halt_evt = wd_evt && halted_r && !hold_rst;
    assign full_rst = hold_rst || wd_run_evt;

    // Low-supply filter counts consecutive low cycles and saturates.
    always_comb begin
        lsr_nxt = '0;
        if (low_supply_enable_i && low_s) begin
            lsr_nxt = (lsr_r == LSR_FIRE) ? lsr_r : lsr_r + 1'b1;
        end
    end

    // Reset sequencer: hold, start-up delay, then run.
    always_comb begin
        state_nxt = state_r;
        sst_nxt = sst_r;
        if (hold_rst) begin
            state_nxt = RSC_HOLD;
            sst_nxt = '0;
        end else if (wd_evt) begin
            state_nxt = RSC_DELAY;
            sst_nxt = '0;
        end else begin
            case (state_r)
                RSC_HOLD: begin
                    state_nxt = RSC_DELAY;
                    sst_nxt = '0;
                end
                RSC_DELAY: begin
                    // Execution stays inhibited for the delay.
                    if (sst_r == SST_LAST) begin
                        state_nxt = RSC_RUN;
                    end else begin
                        sst_nxt = sst_r + 1'b1;
                    end
                end
                RSC_RUN: begin
                    state_nxt = RSC_RUN;
                end
                default: begin
                    state_nxt = RSC_HOLD;
                end
            endcase
        end
    end

    // Watchdog starts from zero once the core runs again.
    always_comb begin
        wdt_nxt = wdt_r;
        if (state_r != RSC_RUN || clr_wdt_i || enter_halt_i || wd_evt) begin
            wdt_nxt = '0;
        end else if (wdt_enable_i) begin
            wdt_nxt = wdt_r + 1'b1;
        end
    end

    // Status flags; hardware sets win over software clears.
    always_comb begin
        to_nxt = to_r;
        pdf_nxt = pdf_r;
        halted_nxt = halted_r;
        cause_nxt = cause_r;
        if (hold_rst) begin
            // Flags kept as they were.
            halted_nxt = 1'b0;
            cause_nxt = '{por: 1'b0, pin: pin_low, low_supply_reset: lvr_active,
                          wd_run: 1'b0, wd_halt: 1'b0};
        end else if (wd_run_evt) begin
            to_nxt = 1'b1;
            cause_nxt = '{por: 1'b0, pin: 1'b0, low_supply_reset: 1'b0,
                          wd_run: 1'b1, wd_halt: 1'b0};
        end else if (wd_halt_evt) begin
            to_nxt = 1'b1;
            pdf_nxt = 1'b1;
            halted_nxt = 1'b0;
            cause_nxt = '{por: 1'b0, pin: 1'b0, low_supply_reset: 1'b0,
                          wd_run: 1'b0, wd_halt: 1'b1};
        end else if (enter_halt_i && state_r == RSC_RUN) begin
            to_nxt = 1'b0;
            pdf_nxt = 1'b1;
            halted_nxt = 1'b1;
        end else if (clr_wdt_i) begin
            to_nxt = 1'b0;
            pdf_nxt = 1'b0;
        end else if (wake_i) begin
            halted_nxt = 1'b0;
        end
    end

    // Register file: software writes, then reset loads by source.
    always_comb begin
        alu_nxt = alu_r;
        interrupt_control_reg_nxt = interrupt_control_reg_r;
        timer_control_reg_nxt = timer_control_reg_r;
        tmr_nxt = tmr_r;
        pa_nxt = pa_r;
        padir_nxt = padir_r;
        pwm_nxt = pwm_r;
        convh_nxt = convh_r;
        convc_nxt = convc_r;
        pcl_nxt = pcl_r;
        sp_nxt = sp_r;
        psc_nxt = full_rst || wd_halt_evt;
        if (bus_i.we) begin
            case (bus_i.addr)
                REG_STATUS: alu_nxt = bus_i.wdata[3:0];
                REG_INT_CTRL: interrupt_control_reg_nxt = bus_i.wdata & INT_CTRL_WMASK;
                REG_TMR_CTRL: timer_control_reg_nxt = bus_i.wdata & TMR_CTRL_WMASK;
                REG_TMR_COUNT: tmr_nxt = bus_i.wdata;
                REG_PA_DATA: pa_nxt = bus_i.wdata;
                REG_PA_DIR: padir_nxt = bus_i.wdata;
                REG_PWM_DUTY: pwm_nxt = bus_i.wdata;
                REG_CONV_HIGH: convh_nxt = bus_i.wdata;
                REG_CONV_CTRL: convc_nxt = bus_i.wdata;
                REG_PC_LOW: pcl_nxt = bus_i.wdata;
                default: begin
                end
            endcase
        end
        // Timer count, duty and result are not loaded by pin, supply or watchdog resets.
        if (full_rst) begin
            interrupt_control_reg_nxt = INT_CTRL_RST;
            timer_control_reg_nxt = TMR_CTRL_RST;
            convc_nxt = CONV_CTRL_RST;
            pa_nxt = PORT_RST;
            padir_nxt = PORT_RST;
            pcl_nxt = PC_LOW_RST;
            sp_nxt = STACK_TOP;
        end else if (wd_halt_evt) begin
            pcl_nxt = PC_LOW_RST;
            sp_nxt = STACK_TOP;
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_comb begin
        rdata_nxt = 8'h00;
        if (bus_i.re) begin
            case (bus_i.addr)
                REG_STATUS: rdata_nxt = {2'b00, to_r, pdf_r, alu_r};
                REG_INT_CTRL: rdata_nxt = interrupt_control_reg_r;
                REG_TMR_CTRL: rdata_nxt = timer_control_reg_r;
                REG_TMR_COUNT: rdata_nxt = tmr_r;
                REG_PA_DATA: rdata_nxt = pa_r;
                REG_PA_DIR: rdata_nxt = padir_r;
                REG_PWM_DUTY: rdata_nxt = pwm_r;
                REG_CONV_HIGH: rdata_nxt = convh_r;
                REG_CONV_CTRL: rdata_nxt = convc_r;
                REG_PC_LOW: rdata_nxt = pcl_r;
                REG_STACK_PTR: rdata_nxt = sp_r;
                REG_CAUSE: rdata_nxt = {3'b000, cause_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Power-on load; the core then waits the start-up delay.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= RSC_DELAY;
            sst_r <= '0;
            lsr_r <= '0;
            wdt_r <= '0;
            halted_r <= 1'b0;
            to_r <= 1'b0;
            pdf_r <= 1'b0;
            alu_r <= ALU_FLAGS_RST;
            interrupt_control_reg_r <= INT_CTRL_RST;
            timer_control_reg_r <= TMR_CTRL_RST;
            tmr_r <= 8'h00;
            pa_r <= PORT_RST;
            padir_r <= PORT_RST;
            pwm_r <= 8'h00;
            convh_r <= 8'h00;
            convc_r <= CONV_CTRL_RST;
            pcl_r <= PC_LOW_RST;
            sp_r <= STACK_TOP;
            rdata_r <= 8'h00;
            psc_r <= 1'b1;
            cause_r <= '{por: 1'b1, pin: 1'b0, low_supply_reset: 1'b0,
                         wd_run: 1'b0, wd_halt: 1'b0};
        end else begin
            state_r <= state_nxt;
            sst_r <= sst_nxt;
            lsr_r <= lsr_nxt;
            wdt_r <= wdt_nxt;
            halted_r <= halted_nxt;
            to_r <= to_nxt;
            pdf_r <= pdf_nxt;
            alu_r <= alu_nxt;
            interrupt_control_reg_r <= interrupt_control_reg_nxt;
            timer_control_reg_r <= timer_control_reg_nxt;
            tmr_r <= tmr_nxt;
            pa_r <= pa_nxt;
            padir_r <= padir_nxt;
            pwm_r <= pwm_nxt;
            convh_r <= convh_nxt;
            convc_r <= convc_nxt;
            pcl_r <= pcl_nxt;
            sp_r <= sp_nxt;
            rdata_r <= rdata_nxt;
            psc_r <= psc_nxt;
            cause_r <= cause_nxt;
        end
    end

    // Outputs come straight from registers; cpu_run_o is decoded from state_r.
    assign rdata_o = rdata_r;
    assign cpu_run_o = (state_r == RSC_RUN);
    assign prescaler_clr_o = psc_r;
    assign timer_run_o = timer_control_reg_r[TMR_RUN_BIT];
    assign interrupt_control_o = interrupt_control_reg_r;
    assign port_a_data_o = pa_r;
    assign port_a_direction_o = padir_r;
    assign program_counter_low_o = pcl_r;
    assign stack_ptr_o = sp_r;
    assign watchdog_expired_flag_o = to_r;
    assign powered_down_flag_o = pdf_r;
    assign cause_o = cause_r;

    // A low pin holds the core with the program counter cleared.
    AST_PIN_CLEARS_PC: assert property (@(posedge mclk_i) disable iff (rst_i)
        pin_low |=> (pcl_r == 8'h00) && !cpu_run_o)
        else $error("pin reset did not clear PC or stop execution");

    AST_LVR_OPTION: assert property (@(posedge mclk_i) disable iff (rst_i)
        !low_supply_enable_i |=> !lvr_active)
        else $error("low-supply reset active while disabled");

    AST_LVR_FILTER: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(lvr_active) |-> $past(lsr_r) == LSR_W'(LSR_CYC))
        else $error("low-supply reset fired before minimum duration");

    AST_WD_RUN_FLAGS: assert property (@(posedge mclk_i) disable iff (rst_i)
        wd_run_evt |=> to_r && (pdf_r == $past(pdf_r)) && !cpu_run_o)
        else $error("running watchdog reset flags wrong");

    AST_WD_HALT_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i)
        wd_halt_evt |=> to_r && pdf_r && (pcl_r == 8'h00)
            && (pa_r == $past(pa_r)) && (timer_control_reg_r == $past(timer_control_reg_r)))
        else $error("power-down watchdog reset changed kept state");

    AST_PIN_KEEPS_FLAGS: assert property (@(posedge mclk_i) disable iff (rst_i)
        hold_rst |=> (to_r == $past(to_r)) && (pdf_r == $past(pdf_r)))
        else $error("pin or supply reset changed status flags");

    AST_STARTUP_DELAY: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(cpu_run_o) |-> $past(state_r) == RSC_DELAY
            && $past(sst_r) == SST_LAST)
        else $error("execution resumed before start-up delay ended");

    AST_FULL_LOADS: assert property (@(posedge mclk_i) disable iff (rst_i)
        full_rst |=> (timer_control_reg_r == TMR_CTRL_RST) && (convc_r == CONV_CTRL_RST)
            && (interrupt_control_reg_r == INT_CTRL_RST) && (padir_r == PORT_RST))
        else $error("full reset did not load control registers");

    AST_WDT_RESTART: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_r != RSC_RUN) |=> (wdt_r == '0))
        else $error("watchdog not cleared during reset");

endmodule : rsc_ctrl

// File: design/rsc_pkg.sv
// Purpose: Shared constants and types for the reset source controller.
// Assumes: System clock of 100 MHz on mclk_i; 8-bit register port.
// Notes: Register offsets are register indices on the plain register port.
package rsc_pkg;

    // Clock and timing figures.
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOW_SUPPLY_MIN_NS = 1000000;
    // Least time, so the count rounds up.
    localparam int LOW_SUPPLY_MIN_CYC =
        (LOW_SUPPLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Start-up delay in system clocks; a plain default.
    localparam int STARTUP_DELAY_CYC = 1024;
    // Watchdog counter width; overflow after 2**12 counting cycles.
    localparam int WDT_BITS = 12;

    // Register port widths.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_INT_CTRL = 4'h1;
    localparam logic [3:0] REG_TMR_CTRL = 4'h2;
    localparam logic [3:0] REG_TMR_COUNT = 4'h3;
    localparam logic [3:0] REG_PA_DATA = 4'h4;
    localparam logic [3:0] REG_PA_DIR = 4'h5;
    localparam logic [3:0] REG_PWM_DUTY = 4'h6;
    localparam logic [3:0] REG_CONV_HIGH = 4'h7;
    localparam logic [3:0] REG_CONV_CTRL = 4'h8;
    localparam logic [3:0] REG_PC_LOW = 4'h9;
    localparam logic [3:0] REG_STACK_PTR = 4'hA;
    localparam logic [3:0] REG_CAUSE = 4'hB;

    // Field positions.
    localparam int STATUS_TO_BIT = 5;
    localparam int STATUS_PDF_BIT = 4;
    localparam int TMR_RUN_BIT = 4;

    // Reset values.
    localparam logic [7:0] INT_CTRL_RST = 8'h00;
    localparam logic [7:0] TMR_CTRL_RST = 8'h08;
    localparam logic [7:0] CONV_CTRL_RST = 8'h40;
    localparam logic [7:0] PORT_RST = 8'hFF;
    localparam logic [7:0] PC_LOW_RST = 8'h00;
    localparam logic [7:0] STACK_TOP = 8'h00;
    localparam logic [3:0] ALU_FLAGS_RST = 4'h0;

    // Writable bits; reserved bits stay zero.
    localparam logic [7:0] INT_CTRL_WMASK = 8'h7F;
    localparam logic [7:0] TMR_CTRL_WMASK = 8'hDF;

    // Sequencer states; hold to delay flips one bit, delay to run flips two.
    typedef enum logic [1:0] {
        RSC_RUN = 2'b00,
        RSC_HOLD = 2'b01,
        RSC_DELAY = 2'b11
    } rsc_state_t;

    // Which reset source acted.
    typedef struct packed {
        logic por;
        logic pin;
        logic low_supply_reset;
        logic wd_run;
        logic wd_halt;
    } rsc_cause_t;

    // Register port request from the master.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } rsc_bus_t;

endpackage : rsc_pkg

// File: design/rsc_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Synchronous active-high reset.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module rsc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk_i,        // System clock.
    input wire logic rst_i,         // Synchronous reset.
    input wire logic [W-1:0] d_i,   // Asynchronous levels.
    output logic [W-1:0] q_o        // Synchronised levels.
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // Shift the pin level through two stages.
    always_comb begin
        meta_nxt = d_i;
        q_nxt = meta_r;
    end

    // The reset value matches the pin's idle level.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule : rsc_sync

// File: dv/rsc_far_side.sv
// Purpose: Reset switch and supply monitor that face the reset controller.
// Assumes: Lines change by non-blocking assignment after a rising edge.
// Notes: The switch line has a pull-up, so released it reads high.
`timescale 1ns/1ps
module rsc_far_side (
    input wire logic mclk_i,  // System clock, used for timing only.
    output logic pin_n_o,     // Reset switch line, active low.
    output logic supply_low_o // Supply monitor, high while supply is low.
);
    // Idle: switch open, supply good.
    initial begin
        pin_n_o = 1'b1;
        supply_low_o = 1'b0;
    end

    // Hold the switch closed for n cycles; the pull-up restores high.
    task automatic press(input int n);
        @(posedge mclk_i);
        pin_n_o <= 1'b0;
        repeat (n) @(posedge mclk_i);
        pin_n_o <= 1'b1;
        #1;
    endtask : press

    // Supply dip of n cycles, so the filter boundary can be probed.
    task automatic dip(input int n);
        @(posedge mclk_i);
        supply_low_o <= 1'b1;
        repeat (n) @(posedge mclk_i);
        supply_low_o <= 1'b0;
        #1;
    endtask : dip
endmodule : rsc_far_side

// File: dv/rsc_ctrl_test.sv
// Purpose: Self-checking bench for the reset source controller.
// Assumes: Short counts: filter 20, start-up 8, watchdog width 4.
// Notes: Flags carry across scenarios, so the run order matters.
`timescale 1ns/1ps
module rsc_ctrl_test;
    import rsc_pkg::*;
    localparam int LSR = 20;
    localparam int STARTUP_DELAY_TIMER = 8;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pin_n, sup_low, run, pclr, trun, to_f, pd_f;
    logic sup_en = 1'b0;
    logic wd_en = 1'b0;
    logic [2:0] ctl = 3'b000;
    rsc_bus_t bus = '0;
    logic [7:0] rdata, interrupt_control_reg, pa_d, pa_dir, program_counter_low, sp;
    rsc_cause_t cause;
    logic [1:0] mon;
    int errors = 0;
    int comparisons = 0;

    // Clock of 100 MHz.
    always #5 mclk_i = ~mclk_i;
    assign mon = {to_f, run};

    rsc_far_side far (.mclk_i(mclk_i), .pin_n_o(pin_n),
        .supply_low_o(sup_low));

    rsc_ctrl #(.LSR_CYC(LSR), .SST_CYC(STARTUP_DELAY_TIMER), .WDT_W(4)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .external_reset_pin_n_i(pin_n),
        .low_supply_det_i(sup_low), .low_supply_enable_i(sup_en),
        .wdt_enable_i(wd_en), .clr_wdt_i(ctl[2]), .enter_halt_i(ctl[1]),
        .wake_i(ctl[0]), .bus_i(bus), .rdata_o(rdata), .cpu_run_o(run),
        .prescaler_clr_o(pclr), .timer_run_o(trun),
        .interrupt_control_o(interrupt_control_reg), .port_a_data_o(pa_d),
        .port_a_direction_o(pa_dir), .program_counter_low_o(program_counter_low),
        .stack_ptr_o(sp), .watchdog_expired_flag_o(to_f),
        .powered_down_flag_o(pd_f), .cause_o(cause));

    task automatic conclude;
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // One write cycle; the strobe drops after the edge that takes it.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
        @(posedge mclk_i);
        bus <= '0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic chkr(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge mclk_i);
        bus <= '0;
        #1;
        chk(rdata, e);
    endtask : chkr

    // One-cycle pulse on clear (2), halt (1) or wake (0).
    task automatic pulse(input int i);
        @(posedge mclk_i);
        ctl[i] <= 1'b1;
        @(posedge mclk_i);
        ctl[i] <= 1'b0;
        #1;
    endtask : pulse

    // Bounded wait for a monitored level; a hang shows as a mismatch.
    task automatic waitv(input int i, input logic v);
        int n;
        n = 0;
        while (mon[i] !== v && n < 300) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk({7'h00, mon[i]}, {7'h00, v});
    endtask : waitv

    // Move interrupt control, timer control and count, port A and PC low off their reset values.
    task automatic dirty;
        wr(REG_INT_CTRL, 8'h55);
        wr(REG_TMR_CTRL, 8'h10);
        wr(REG_PA_DATA, 8'h0F);
        wr(REG_PA_DIR, 8'h0F);
        wr(REG_PC_LOW, 8'h33);
        wr(REG_TMR_COUNT, 8'h5A);
    endtask : dirty

    task automatic full_chk;
        chkr(REG_INT_CTRL, 8'h00);
        chkr(REG_TMR_CTRL, 8'h08);
        chkr(REG_CONV_CTRL, 8'h40);
        chkr(REG_PA_DATA, 8'hFF);
        chkr(REG_PA_DIR, 8'hFF);
        chkr(REG_PC_LOW, 8'h00);
        chkr(REG_STACK_PTR, 8'h00);
        chk({7'h00, trun}, 8'h00);
        chk({7'h00, pclr}, 8'h00);
        chk(interrupt_control_reg, 8'h00);
        chk(pa_d, 8'hFF);
        chk(pa_dir, 8'hFF);
        chk(program_counter_low, 8'h00);
        chk(sp, 8'h00);
    endtask : full_chk

    task automatic t_por;
        int n;
        n = 0;
        @(posedge mclk_i);
        rst_i <= 1'b0;
        while (run !== 1'b1 && n < 100) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        // The delay spans STARTUP_DELAY_TIMER edges counted from the first free edge.
        chk(8'(n), 8'(STARTUP_DELAY_TIMER));
        chk({6'h00, to_f, pd_f}, 8'h00);
        full_chk();
        chkr(4'hC, 8'h00);
    endtask : t_por

    task automatic t_pin;
        dirty();
        pulse(1);
        pulse(0);
        far.press(6);
        waitv(0, 1'b0);
        waitv(0, 1'b1);
        chk({6'h00, to_f, pd_f}, 8'h01);
        chk({3'h0, cause}, 8'h08);
        full_chk();
    endtask : t_pin

    task automatic t_wdrun;
        dirty();
        @(posedge mclk_i);
        wd_en <= 1'b1;
        waitv(0, 1'b0);
        chk({7'h00, pclr}, 8'h01);
        chk({6'h00, to_f, pd_f}, 8'h03);
        @(posedge mclk_i);
        wd_en <= 1'b0;
        waitv(0, 1'b1);
        chk({3'h0, cause}, 8'h02);
        full_chk();
    endtask : t_wdrun

    task automatic low_supply_min_duration;
        dirty();
        far.dip(40);
        repeat (5) @(posedge mclk_i);
        chkr(REG_PA_DIR, 8'h0F);
        @(posedge mclk_i);
        sup_en <= 1'b1;
        far.dip(LSR);
        repeat (5) @(posedge mclk_i);
        chkr(REG_PA_DIR, 8'h0F);
        far.dip(LSR + 4);
        waitv(0, 1'b0);
        waitv(0, 1'b1);
        chk({6'h00, to_f, pd_f}, 8'h03);
        chk({3'h0, cause}, 8'h04);
        full_chk();
    endtask : low_supply_min_duration

    task automatic t_wdhalt;
        pulse(2);
        chk({6'h00, to_f, pd_f}, 8'h00);
        dirty();
        pulse(1);
        @(posedge mclk_i);
        wd_en <= 1'b1;
        waitv(1, 1'b1);
        chk({6'h00, to_f, pd_f}, 8'h03);
        @(posedge mclk_i);
        wd_en <= 1'b0;
        pulse(0);
        chk({3'h0, cause}, 8'h01);
        chkr(REG_PA_DIR, 8'h0F);
        chkr(REG_INT_CTRL, 8'h55);
        chkr(REG_TMR_COUNT, 8'h5A);
        chkr(REG_PC_LOW, 8'h00);
        chkr(REG_STACK_PTR, 8'h00);
        chk({7'h00, trun}, 8'h01);
    endtask : t_wdhalt

    // Main sequence: reset held seven cycles, then each scenario in turn.
    initial begin
        repeat (6) @(posedge mclk_i);
        t_por();
        t_pin();
        t_wdrun();
        low_supply_min_duration();
        t_wdhalt();
        conclude();
    end

    // The scenarios need a few hundred cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        conclude();
    end
endmodule : rsc_ctrl_test
